// ==== verilog/asp_cfg.svh ====
// Constants for the 4Kx4 asynchronous SRAM host controller.
// Assumes a 20 MHz core clock; all counts are cycles of that clock.
// Function
// RULE1 - Chip select low selects one 4-bit word
// RULE2 - Wait 2ms after power before any access
// RULE3 - Chip select high deselects, outputs float
// RULE4 - Write strobe stays high for whole read
// RULE5 - Address read: data valid after access time
// RULE6 - Back-to-back reads need no recovery gap
// RULE7 - Address stable within 5ns of select fall
// RULE8 - Select access independent of deselect time
// RULE9 - Write spans later fall to first rise
// RULE10 - Device stores data, its drivers float
// RULE11 - Address set up before write begins
// RULE12 - Address held until write ends
// RULE13 - Data set-up and hold around strobe rise
// RULE14 - Select-ended write leaves outputs floating
// RULE15 - Round all times up to whole cycles
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_ADDR_W 12
`define ASP_DATA_W 4
`define ASP_CLK_PERIOD_NS 50
`define ASP_POWERUP_NS 2000000
`define ASP_POWERUP_CYC ((`ASP_POWERUP_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_ACCESS_NS 70
`define ASP_ACCESS_CYC ((`ASP_ACCESS_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_WPULSE_NS 65
`define ASP_WPULSE_CYC ((`ASP_WPULSE_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_HOLD_NS 5
`define ASP_HOLD_CYC ((`ASP_HOLD_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_HZ_NS 30
`define ASP_HZ_CYC ((`ASP_HZ_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_CNT_W 16
`endif

// ==== verilog/asp_pkg.sv ====
// Types for the SRAM host controller.
// Assumes asp_cfg.svh is compiled with it.
`include "asp_cfg.svh"
package asp_pkg;
  typedef logic [`ASP_ADDR_W-1:0] asp_addr_t;
  typedef logic [`ASP_DATA_W-1:0] asp_data_t;
  typedef logic [`ASP_CNT_W-1:0] asp_cnt_t;
  typedef enum logic [2:0] {
    ASP_POWERUP, ASP_IDLE, ASP_RD_ACCESS, ASP_WR_SETUP, ASP_WR_PULSE, ASP_WR_HOLD, ASP_TURN
  } asp_state_t;
endpackage

// ==== verilog/asp_delay.sv ====
// Down-counter used for every timed phase of the controller except the power-up wait.
// Assumes single clock, load and count run synchronously.
`timescale 1ns/1ps
module asp_delay
  import asp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire asp_pkg::asp_cnt_t load_val,
  output logic done
);
  asp_cnt_t cnt_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - asp_cnt_t'(1);
    end
  end
  // Count alone; the caller decodes load from done
  assign done = (cnt_r == '0);
endmodule

// ==== verilog/asp_host.sv ====
// Host controller driving a 4Kx4 asynchronous static RAM over its pins.
// Assumes user requests synchronous to core_clk and SRAM pins sampled on it.
`timescale 1ns/1ps
`include "asp_cfg.svh"
module asp_host
  import asp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire asp_pkg::asp_addr_t req_addr,
  input wire asp_pkg::asp_data_t req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output asp_pkg::asp_data_t rsp_rdata,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output asp_pkg::asp_addr_t word_addr_bus,
  output asp_pkg::asp_data_t data_out,
  output logic data_oe,
  input wire asp_pkg::asp_data_t data_in
);
  import asp_pkg::*;

  asp_state_t state_r;
  logic dly_load;
  asp_cnt_t dly_val;
  logic dly_done;

  function automatic asp_cnt_t cyc(input int n);
    cyc = asp_cnt_t'(n - 1);
  endfunction

  asp_delay u_delay (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(dly_load),
    .load_val(dly_val),
    .done(dly_done)
  );

  logic take;
  assign take = (state_r == ASP_IDLE) && req_valid;

  always_comb begin
    dly_load = 1'b0;
    dly_val = '0;
    unique case (state_r)
      ASP_POWERUP: begin
        dly_load = 1'b0;
      end
      ASP_IDLE: begin
        if (take && !req_write) begin
          dly_load = 1'b1;
          dly_val = cyc(`ASP_ACCESS_CYC);
        end else if (take) begin
          dly_load = 1'b1;
          dly_val = cyc(1);
        end
      end
      ASP_WR_SETUP: begin
        if (dly_done) begin
          dly_load = 1'b1;
          dly_val = cyc(`ASP_WPULSE_CYC);
        end
      end
      ASP_WR_PULSE: begin
        if (dly_done) begin
          dly_load = 1'b1;
          dly_val = cyc(`ASP_HOLD_CYC);
        end
      end
      ASP_WR_HOLD, ASP_RD_ACCESS: begin
        if (dly_done) begin
          dly_load = 1'b1;
          dly_val = cyc(`ASP_HZ_CYC);
        end
      end
      ASP_TURN: begin
        dly_load = 1'b0;
      end
    endcase
  end

  // Power-up wait counter
  logic [21:0] pwr_cnt_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_cnt_r <= '0;
    end else if (state_r == ASP_POWERUP) begin
      pwr_cnt_r <= pwr_cnt_r + 22'h1;
    end
  end

  // Phase ends shared by the pin processes
  function automatic logic phase_end(input asp_state_t cur, input asp_state_t phase, input logic done);
    phase_end = (cur == phase) && done;
  endfunction

  logic pwr_end;
  logic rd_end;
  logic wr_setup_end;
  logic wr_pulse_end;
  logic wr_hold_end;
  logic turn_end;
  // RULE2 hold off 2ms
  assign pwr_end = (state_r == ASP_POWERUP) && (pwr_cnt_r == 22'(`ASP_POWERUP_CYC - 1));
  assign rd_end = phase_end(state_r, ASP_RD_ACCESS, dly_done);
  assign wr_setup_end = phase_end(state_r, ASP_WR_SETUP, dly_done);
  assign wr_pulse_end = phase_end(state_r, ASP_WR_PULSE, dly_done);
  assign wr_hold_end = phase_end(state_r, ASP_WR_HOLD, dly_done);
  assign turn_end = phase_end(state_r, ASP_TURN, dly_done);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ASP_POWERUP;
    end else begin
      unique case (state_r)
        ASP_POWERUP: begin
          if (pwr_end) begin
            state_r <= ASP_IDLE;
          end
        end
        ASP_IDLE: begin
          if (take) begin
            state_r <= req_write ? ASP_WR_SETUP : ASP_RD_ACCESS;
          end
        end
        ASP_RD_ACCESS: begin
          if (rd_end) begin
            state_r <= ASP_TURN;
          end
        end
        ASP_WR_SETUP: begin
          if (wr_setup_end) begin
            state_r <= ASP_WR_PULSE;
          end
        end
        ASP_WR_PULSE: begin
          if (wr_pulse_end) begin
            state_r <= ASP_WR_HOLD;
          end
        end
        ASP_WR_HOLD: begin
          if (wr_hold_end) begin
            state_r <= ASP_TURN;
          end
        end
        ASP_TURN: begin
          if (turn_end) begin
            state_r <= ASP_IDLE;
          end
        end
      endcase
    end
  end

  // RULE1 RULE3 select only during access
  // RULE8 no dependence on idle time
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_sel_n <= 1'b1;
    end else if (take) begin
      chip_sel_n <= 1'b0;
    end else if (rd_end || wr_hold_end) begin
      chip_sel_n <= 1'b1;
    end
  end

  // RULE4 RULE9 strobe low only in pulse
  // RULE13 rising edge ends the write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_strobe_n <= 1'b1;
    end else if (wr_setup_end) begin
      write_strobe_n <= 1'b0;
    end else if (wr_pulse_end) begin
      write_strobe_n <= 1'b1;
    end
  end

  // RULE7 RULE11 RULE12 address set with select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_addr_bus <= '0;
    end else if (take) begin
      word_addr_bus <= req_addr;
    end
  end

  // RULE10 RULE13 host drives data around pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else if (take && req_write) begin
      data_out <= req_wdata;
      data_oe <= 1'b1;
    end else if (wr_hold_end) begin
      data_oe <= 1'b0;
    end
  end

  // RULE5 RULE15 sample after rounded access time
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= rd_end;
      if (rd_end) begin
        rsp_rdata <= data_in;
      end
    end
  end

  // RULE6 RULE14 ready after turnaround
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
    end else if (take) begin
      req_ready <= 1'b0;
    end else if (pwr_end || turn_end) begin
      req_ready <= 1'b1;
    end
  end
endmodule

// ==== dv/asp_host_assertions.sv ====
// Pin sequencing checks for the SRAM host controller.
// Assumes binding to asp_host.
`timescale 1ns/1ps
module asp_host_assertions
  import asp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rsp_valid,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire asp_pkg::asp_addr_t word_addr_bus,
  input wire asp_pkg::asp_data_t data_out,
  input wire logic data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  rd_strobe_a: assert property (!chip_sel_n && !data_oe |-> write_strobe_n)
    else $error("strobe low in read");
  wr_start_a: assert property ($fell(write_strobe_n) |-> !chip_sel_n && data_oe && !$past(chip_sel_n))
    else $error("write start");
  wr_addr_a: assert property (!write_strobe_n |-> $stable(word_addr_bus) && $stable(data_out))
    else $error("write addr moved");
  wr_pulse_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("write pulse");
  wr_hold_a: assert property ($rose(write_strobe_n) |-> data_oe && !chip_sel_n ##1 chip_sel_n && !data_oe)
    else $error("write hold");
  rd_addr_a: assert property ($fell(chip_sel_n) |=> $stable(word_addr_bus))
    else $error("read addr");
  rd_data_a: assert property ($fell(chip_sel_n) && !data_oe |-> ##2 rsp_valid && chip_sel_n)
    else $error("read answer");
  oe_sel_a: assert property (data_oe |-> !chip_sel_n)
    else $error("drive unselected");
  cover property ($rose(rsp_valid));
  cover property ($fell(write_strobe_n));
  cover property ($rose(data_oe));
endmodule
bind asp_host asp_host_assertions u_chk (.*);

// ==== dv/asp_sram_model.sv ====
// Behavioural 4Kx4 asynchronous SRAM.
// Assumes data_in is the resolved level of the shared data lines.
`timescale 1ns/1ps
module asp_sram_model
  import asp_pkg::*;
(
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire asp_pkg::asp_addr_t word_addr_bus,
  input wire asp_pkg::asp_data_t data_out,
  input wire logic data_oe,
  output asp_pkg::asp_data_t data_in
);
  asp_data_t mem [4096];
  asp_data_t q = 4'h0;
  logic up = 1'b0;
  initial #2000000 up = 1'b1;
  always @(word_addr_bus or chip_sel_n or write_strobe_n) q <= #70 mem[word_addr_bus];
  // drive q only in read, else host data or the inverted q
  assign data_in = data_oe ? data_out : (up && !chip_sel_n && write_strobe_n) ? q : ~q;
  always @(posedge write_strobe_n or posedge chip_sel_n) begin
    if (up && (chip_sel_n ^ write_strobe_n))
      mem[word_addr_bus] = data_in;
  end
endmodule

// ==== dv/tb_asp_host.sv ====
// Self-checking bench for asp_host with a behavioural SRAM.
// Assumes the full 2ms power-up wait.
`timescale 1ns/1ps
`include "asp_cfg.svh"
module tb_asp_host;
  import asp_pkg::*;
  logic core_clk, reset_n, req_valid, req_write, req_ready, rsp_valid, chip_sel_n, write_strobe_n, data_oe;
  asp_addr_t req_addr, word_addr_bus;
  asp_data_t req_wdata, rsp_rdata, data_out, data_in;
  int n_mismatch = 0;
  int comparisons = 0;
  asp_addr_t ad[4] = '{12'h000, 12'hfff, 12'h5a5, 12'h001};
  asp_host dut (.*);
  asp_sram_model mem (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic req(input logic w, input asp_addr_t a, input asp_data_t d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    chk("ready at take", 16'h1, 16'(req_ready));
    n = 0;
    if (!w) begin
      do begin
        @(posedge core_clk);
        #1;
        n++;
      end while (rsp_valid !== 1'b1 && n < 20);
      chk("read latency", 16'(`ASP_ACCESS_CYC), n[15:0]);
      chk("read data", 16'(d), 16'(rsp_rdata));
    end
  endtask
  task automatic t_powerup;
    repeat (20000) @(posedge core_clk);
    chk("ready in standby", 16'h0, 16'(req_ready));
    chk("select in standby", 16'h1, 16'(chip_sel_n));
    for (int n = 0; n < 30000 && req_ready !== 1'b1; n++) @(posedge core_clk);
    chk("ready after wait", 16'h1, 16'(req_ready));
    $display("test powerup done");
  endtask
  task automatic t_rw;
    for (int k = 0; k < 2; k++) begin
      foreach (ad[i]) req(1'b1, ad[i], 4'(i * 5 + k * 7 + 3));
      foreach (ad[i]) req(1'b0, ad[i], 4'(i * 5 + k * 7 + 3));
    end
    $display("test write read done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #4000000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 12'h000;
    req_wdata = 4'h0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_powerup;
    t_rw;
    report_and_stop;
  end
endmodule
